/* File: design/igrm_pkg.sv */
`default_nettype none
package igrm_pkg;

  localparam int unsigned IGRM_DEVS      = 16;
  localparam int unsigned IGRM_VARS      = 4;
  localparam int unsigned IGRM_TAG_BITS  = 64;
  localparam int unsigned IGRM_EXT_BYTES = 25;

  // Register numbers, zero based
  localparam logic [15:0] IGRM_PRIMARY_VALUE_INT_ARRAY     = 16'h0000;
  localparam logic [15:0] IGRM_SECONDARY_VALUE_INT_ARRAY   = 16'h0010;
  localparam logic [15:0] IGRM_THIRD_VALUE_INT_ARRAY       = 16'h0020;
  localparam logic [15:0] IGRM_FOURTH_VALUE_INT_ARRAY      = 16'h0030;
  localparam logic [15:0] IGRM_INSTRUMENT_STATUS_ARRAY     = 16'h0040;
  localparam logic [15:0] IGRM_UNIT_CODES_FIRST_PAIR       = 16'h0050;
  localparam logic [15:0] IGRM_UNIT_CODES_SECOND_PAIR      = 16'h0060;
  localparam logic [15:0] IGRM_UNIT_CODES_END              = 16'h006f;
  localparam logic [15:0] IGRM_GATEWAY_STATUS              = 16'h007f;
  localparam logic [15:0] IGRM_PRIMARY_VALUE_FLOAT_ARRAY   = 16'h0100;
  localparam logic [15:0] IGRM_SECONDARY_VALUE_FLOAT_ARRAY = 16'h0120;
  localparam logic [15:0] IGRM_THIRD_VALUE_FLOAT_ARRAY     = 16'h0140;
  localparam logic [15:0] IGRM_FOURTH_VALUE_FLOAT_ARRAY    = 16'h0160;
  localparam logic [15:0] IGRM_FLOAT_END                   = 16'h017f;
  localparam logic [15:0] IGRM_LEGACY_EXTRA_STATUS_BYTES   = 16'h0200;
  localparam logic [15:0] IGRM_LEGACY_EXTRA_END            = 16'h025f;
  localparam logic [15:0] IGRM_EXTENDED_EXTRA_STATUS_BYTES = 16'h03e8;
  localparam logic [15:0] IGRM_EXTENDED_EXTRA_END          = 16'h0577;

  localparam logic [15:0] IGRM_LEGACY_STRIDE   = 16'h0006;
  localparam logic [15:0] IGRM_EXTENDED_STRIDE = 16'h0019;
  localparam logic [4:0]  IGRM_EXT_COUNT_MAX   = 5'h19;

  localparam logic [31:0] IGRM_FLOAT_NAN   = 32'h7fc00000;
  localparam logic [15:0] IGRM_TAG_OK_RST  = 16'hffff;
  localparam logic [15:0] IGRM_INT_MAX     = 16'h7fff;
  localparam logic [15:0] IGRM_INT_MIN     = 16'h8000;
  localparam logic [1:0]  IGRM_DP_MAX      = 2'h3;

  typedef enum logic [2:0] {
    IGRM_UPD_VALUE,
    IGRM_UPD_STATUS,
    IGRM_UPD_UNIT,
    IGRM_UPD_TAG,
    IGRM_UPD_EXTRA_LEN,
    IGRM_UPD_EXTRA_BYTE,
    IGRM_UPD_FAIL,
    IGRM_UPD_LINK_OK
  } igrm_upd_kind_type;

  typedef enum logic [1:0] {
    IGRM_FAIL_HOLD,
    IGRM_FAIL_PRESET,
    IGRM_FAIL_NAN,
    IGRM_FAIL_RSVD
  } igrm_fail_mode_type;

endpackage : igrm_pkg
`default_nettype wire

/* File: design/igrm_scale_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface igrm_scale_if;
  logic [15:0] raw;
  logic [1:0]  dp;
  logic [15:0] scaled;
  modport user   (output raw, output dp, input scaled);
  modport scaler (input raw, input dp, output scaled);
endinterface : igrm_scale_if
`default_nettype wire

/* File: design/igrm_scaler.sv */
`timescale 1ns/10ps
`default_nettype none
module igrm_scaler
  import igrm_pkg::*;
(
  igrm_scale_if.scaler sc
);

  function automatic logic [15:0] igrm_mul10_sat(input logic [15:0] x);
    logic signed [19:0] w;
    w = (20'(signed'(x)) <<< 3) + (20'(signed'(x)) <<< 1);
    if (w > 20'(signed'({1'b0, IGRM_INT_MAX[14:0]}))) begin
      igrm_mul10_sat = IGRM_INT_MAX;
    end else if (w < -20'sh08000) begin
      igrm_mul10_sat = IGRM_INT_MIN;
    end else begin
      igrm_mul10_sat = w[15:0];
    end
  endfunction : igrm_mul10_sat

  // Times ten per decimal point, saturating
  always_comb begin
    logic [15:0] v;
    v = sc.raw;
    for (int i = 0; i < 3; i++) begin
      if (2'(i) < sc.dp) begin
        v = igrm_mul10_sat(v);
      end
    end
    sc.scaled = v;
  end

endmodule : igrm_scaler
`default_nettype wire

/* File: design/igrm_top.sv */
`timescale 1ns/10ps
`default_nettype none
module igrm_top
  import igrm_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        monitor_en,
  input  wire logic        cfg_extended,
  input  wire logic        cfg_high_half_first,
  input  wire logic [1:0]  cfg_fail_mode,
  input  wire logic [31:0] cfg_preset_float,
  input  wire logic [15:0] cfg_preset_int,
  input  wire logic [1:0]  cfg_decimal_point_count,
  input  wire logic [15:0] gw_status,
  input  wire logic        upd_valid,
  input  wire logic [2:0]  upd_kind,
  input  wire logic [3:0]  upd_dev,
  input  wire logic [4:0]  upd_sel,
  input  wire logic [31:0] upd_data,
  input  wire logic [15:0] upd_int,
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_addr,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  input  wire logic [3:0]  tag_dev,
  output logic [63:0]      tag_data,
  output logic [15:0]      dev_found,
  output logic [15:0]      dev_failed
);

  typedef struct packed {
    logic [15:0][3:0][31:0] flt;
    logic [15:0][3:0][15:0] ival;
    logic [15:0][15:0]      stat;
    logic [15:0][3:0][7:0]  unit;
    logic [15:0][63:0]      tag;
    logic [15:0][24:0][7:0] xb;
    logic [15:0][4:0]       xcnt;
    logic [15:0]            found;
    logic [15:0]            failed;
    logic [15:0]            tag_ok;
    logic [15:0]            rd_data;
    logic                   rd_valid;
    logic [63:0]            tag_data;
  } igrm_state_type;

  igrm_state_type st_r;
  igrm_state_type st_nxt;

  igrm_scale_if scl ();

  igrm_scaler u_scaler (
    .sc (scl.scaler)
  );

  assign scl.raw = upd_int;
  assign scl.dp  = cfg_decimal_point_count;

  // Extra status byte, zero past the received count
  function automatic logic [15:0] igrm_extra(input igrm_state_type s,
                                             input logic [3:0] d,
                                             input logic [4:0] b);
    if (b < s.xcnt[d]) begin
      igrm_extra = {8'h00, s.xb[d][b]};
    end else begin
      igrm_extra = 16'h0000;
    end
  endfunction : igrm_extra

  function automatic logic igrm_in(input logic [15:0] a,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    igrm_in = (a >= lo) && (a <= hi);
  endfunction : igrm_in

  always_comb begin
    logic [15:0] off;
    logic [15:0] dq;
    logic [15:0] bq;
    logic [31:0] w;
    logic [15:0] rdat;
    st_nxt = st_r;
    off    = 16'h0000;
    dq     = 16'h0000;
    bq     = 16'h0000;
    w      = 32'h00000000;
    rdat   = 16'h0000;

    // Update side
    if (upd_valid) begin
      case (igrm_upd_kind_type'(upd_kind))
        IGRM_UPD_VALUE: begin
          if (monitor_en) begin
            st_nxt.flt[upd_dev][upd_sel[1:0]]  = upd_data;
            st_nxt.ival[upd_dev][upd_sel[1:0]] = scl.scaled;
            st_nxt.found[upd_dev]              = 1'b1;
          end
        end
        IGRM_UPD_STATUS: begin
          st_nxt.stat[upd_dev] = upd_data[15:0];
        end
        IGRM_UPD_UNIT: begin
          st_nxt.unit[upd_dev][upd_sel[1:0]] = upd_data[7:0];
        end
        IGRM_UPD_TAG: begin
          if (st_r.tag_ok[upd_dev]) begin
            if (upd_sel[0]) begin
              st_nxt.tag[upd_dev][31:0]   = upd_data;
              st_nxt.tag_ok[upd_dev]      = 1'b0;
            end else begin
              st_nxt.tag[upd_dev][63:32]  = upd_data;
            end
          end
        end
        IGRM_UPD_EXTRA_LEN: begin
          if (upd_data[4:0] > IGRM_EXT_COUNT_MAX) begin
            st_nxt.xcnt[upd_dev] = IGRM_EXT_COUNT_MAX;
          end else begin
            st_nxt.xcnt[upd_dev] = upd_data[4:0];
          end
        end
        IGRM_UPD_EXTRA_BYTE: begin
          if (upd_sel < IGRM_EXT_COUNT_MAX) begin
            st_nxt.xb[upd_dev][upd_sel] = upd_data[7:0];
          end
        end
        IGRM_UPD_FAIL: begin
          st_nxt.failed[upd_dev] = 1'b1;
          case (igrm_fail_mode_type'(cfg_fail_mode))
            IGRM_FAIL_PRESET: begin
              for (int v = 0; v < IGRM_VARS; v++) begin
                st_nxt.flt[upd_dev][v]  = cfg_preset_float;
                st_nxt.ival[upd_dev][v] = cfg_preset_int;
              end
            end
            IGRM_FAIL_NAN: begin
              for (int v = 0; v < IGRM_VARS; v++) begin
                st_nxt.flt[upd_dev][v] = IGRM_FLOAT_NAN;
              end
            end
            default: begin
            end
          endcase
        end
        IGRM_UPD_LINK_OK: begin
          if (st_r.failed[upd_dev]) begin
            st_nxt.tag_ok[upd_dev] = 1'b1;
          end
          st_nxt.failed[upd_dev] = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // Read side, register numbers taken as zero based
    if (igrm_in(rd_addr, IGRM_PRIMARY_VALUE_INT_ARRAY, IGRM_INSTRUMENT_STATUS_ARRAY - 16'h0001))
    begin
      rdat = st_r.ival[rd_addr[3:0]][rd_addr[5:4]];
    end else if (igrm_in(rd_addr, IGRM_INSTRUMENT_STATUS_ARRAY,
                         IGRM_UNIT_CODES_FIRST_PAIR - 16'h0001)) begin
      rdat = st_r.stat[rd_addr[3:0]];
    end else if (igrm_in(rd_addr, IGRM_UNIT_CODES_FIRST_PAIR,
                         IGRM_UNIT_CODES_SECOND_PAIR - 16'h0001)) begin
      rdat = {st_r.unit[rd_addr[3:0]][0], st_r.unit[rd_addr[3:0]][1]};
    end else if (igrm_in(rd_addr, IGRM_UNIT_CODES_SECOND_PAIR, IGRM_UNIT_CODES_END)) begin
      rdat = {st_r.unit[rd_addr[3:0]][2], st_r.unit[rd_addr[3:0]][3]};
    end else if (rd_addr == IGRM_GATEWAY_STATUS) begin
      rdat = gw_status;
    end else if (igrm_in(rd_addr, IGRM_PRIMARY_VALUE_FLOAT_ARRAY, IGRM_FLOAT_END)) begin
      off = rd_addr - IGRM_PRIMARY_VALUE_FLOAT_ARRAY;
      w   = st_r.flt[off[4:1]][off[6:5]];
      if (off[0] ^ cfg_high_half_first) begin
        rdat = w[31:16];
      end else begin
        rdat = w[15:0];
      end
    end else if (igrm_in(rd_addr, IGRM_LEGACY_EXTRA_STATUS_BYTES, IGRM_LEGACY_EXTRA_END)) begin
      off  = rd_addr - IGRM_LEGACY_EXTRA_STATUS_BYTES;
      dq   = off / IGRM_LEGACY_STRIDE;
      bq   = off % IGRM_LEGACY_STRIDE;
      rdat = igrm_extra(st_r, dq[3:0], bq[4:0]);
    end else if (cfg_extended && igrm_in(rd_addr, IGRM_EXTENDED_EXTRA_STATUS_BYTES,
                                         IGRM_EXTENDED_EXTRA_END)) begin
      off  = rd_addr - IGRM_EXTENDED_EXTRA_STATUS_BYTES;
      dq   = off / IGRM_EXTENDED_STRIDE;
      bq   = off % IGRM_EXTENDED_STRIDE;
      rdat = igrm_extra(st_r, dq[3:0], bq[4:0]);
    end

    st_nxt.rd_valid = rd_req;
    if (rd_req) begin
      st_nxt.rd_data = rdat;
    end
    st_nxt.tag_data = st_r.tag[tag_dev];
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r        <= '0;
      st_r.tag_ok <= IGRM_TAG_OK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_valid   = st_r.rd_valid;
  assign rd_data    = st_r.rd_data;
  assign tag_data   = st_r.tag_data;
  assign dev_found  = st_r.found;
  assign dev_failed = st_r.failed;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_read;
    rd_req;
  endsequence

  sequence s_value_upd;
    upd_valid && (upd_kind == IGRM_UPD_VALUE) && monitor_en;
  endsequence

  sequence s_fail_nan;
    upd_valid && (upd_kind == IGRM_UPD_FAIL) && (cfg_fail_mode == IGRM_FAIL_NAN);
  endsequence

  sequence s_tag_locked;
    upd_valid && (upd_kind == IGRM_UPD_TAG) && !st_r.tag_ok[upd_dev];
  endsequence

  sequence s_value_refused;
    upd_valid && (upd_kind == IGRM_UPD_VALUE) && !monitor_en;
  endsequence

  sequence s_fail_preset;
    upd_valid && (upd_kind == IGRM_UPD_FAIL) && (cfg_fail_mode == IGRM_FAIL_PRESET);
  endsequence

  sequence s_fail_hold;
    upd_valid && (upd_kind == IGRM_UPD_FAIL) && (cfg_fail_mode == IGRM_FAIL_HOLD);
  endsequence

  sequence s_relink;
    upd_valid && (upd_kind == IGRM_UPD_LINK_OK) && st_r.failed[upd_dev];
  endsequence

  a_read_answer: assert property (s_read |=> rd_valid ##1 !rd_valid || $past(rd_req))
    else $error("read answer timing wrong");

  a_gap_zero: assert property (
    s_read and igrm_in(rd_addr, IGRM_UNIT_CODES_END + 16'h0001, IGRM_GATEWAY_STATUS - 16'h0001)
    |=> rd_data == 16'h0000)
    else $error("unassigned register not zero");

  a_gw_status: assert property (s_read and (rd_addr == IGRM_GATEWAY_STATUS)
    |=> rd_data == $past(gw_status))
    else $error("gateway status word wrong");

  a_int_read: assert property (s_read and (rd_addr < IGRM_INSTRUMENT_STATUS_ARRAY)
    |=> rd_data == $past(st_r.ival[rd_addr[3:0]][rd_addr[5:4]]))
    else $error("integer register wrong");

  a_unit_pack: assert property (s_read and (rd_addr == IGRM_UNIT_CODES_FIRST_PAIR)
    |=> rd_data == {$past(st_r.unit[0][0]), $past(st_r.unit[0][1])})
    else $error("unit code packing wrong");

  a_float_order: assert property (
    s_read and igrm_in(rd_addr, IGRM_PRIMARY_VALUE_FLOAT_ARRAY, IGRM_FLOAT_END)
    and !rd_addr[0] and !cfg_high_half_first
    |=> rd_data == $past(st_r.flt[rd_addr[4:1]][rd_addr[6:5]][15:0]))
    else $error("float low half not first");

  a_ext_hidden: assert property (
    s_read and !cfg_extended
    and igrm_in(rd_addr, IGRM_EXTENDED_EXTRA_STATUS_BYTES, IGRM_EXTENDED_EXTRA_END)
    |=> rd_data == 16'h0000)
    else $error("extended bytes visible in legacy variant");

  a_legacy_count: assert property (
    s_read and igrm_in(rd_addr, IGRM_LEGACY_EXTRA_STATUS_BYTES + 16'h000c,
                       IGRM_LEGACY_EXTRA_STATUS_BYTES + 16'h0011)
    and (5'(rd_addr - IGRM_LEGACY_EXTRA_STATUS_BYTES - 16'h000c) >= st_r.xcnt[2])
    |=> rd_data == 16'h0000)
    else $error("unreceived extra byte shown");

  a_value_found: assert property (s_value_upd |=> st_r.found[$past(upd_dev)])
    else $error("value update not taken");

  a_nan_load: assert property (s_fail_nan |=>
    st_r.flt[$past(upd_dev)][0] == IGRM_FLOAT_NAN && st_r.failed[$past(upd_dev)])
    else $error("NaN not loaded on failure");

  a_tag_locked: assert property (s_tag_locked |=> $stable(st_r.tag))
    else $error("tag changed during ordinary polling");

  a_scaled_store: assert property (
    s_value_upd and (cfg_decimal_point_count == 2'h0)
    |=> st_r.ival[$past(upd_dev)][$past(upd_sel[1:0])] == $past(upd_int))
    else $error("unscaled integer not stored as sent");

  a_status_read: assert property (
    s_read and igrm_in(rd_addr, IGRM_INSTRUMENT_STATUS_ARRAY,
                       IGRM_UNIT_CODES_FIRST_PAIR - 16'h0001)
    |=> rd_data == $past(st_r.stat[rd_addr[3:0]]))
    else $error("instrument status word wrong");

  a_unit_second: assert property (
    s_read and igrm_in(rd_addr, IGRM_UNIT_CODES_SECOND_PAIR, IGRM_UNIT_CODES_END)
    |=> rd_data == {$past(st_r.unit[rd_addr[3:0]][2]), $past(st_r.unit[rd_addr[3:0]][3])})
    else $error("second unit pair wrong");

  a_float_swap: assert property (
    s_read and igrm_in(rd_addr, IGRM_PRIMARY_VALUE_FLOAT_ARRAY, IGRM_FLOAT_END)
    and !rd_addr[0] and cfg_high_half_first
    |=> rd_data == $past(st_r.flt[rd_addr[4:1]][rd_addr[6:5]][31:16]))
    else $error("swapped float high half not first");

  a_float_second: assert property (
    s_read and igrm_in(rd_addr, IGRM_PRIMARY_VALUE_FLOAT_ARRAY, IGRM_FLOAT_END)
    and rd_addr[0] and !cfg_high_half_first
    |=> rd_data == $past(st_r.flt[rd_addr[4:1]][rd_addr[6:5]][31:16]))
    else $error("float high half not second");

  a_value_refused: assert property (
    s_value_refused |=> $stable(st_r.flt) && $stable(st_r.ival))
    else $error("value taken while not monitoring");

  a_preset_load: assert property (s_fail_preset |=>
    st_r.flt[$past(upd_dev)][0] == $past(cfg_preset_float)
    && st_r.ival[$past(upd_dev)][0] == $past(cfg_preset_int))
    else $error("preset not loaded on failure");

  a_hold_keep: assert property (
    s_fail_hold |=> $stable(st_r.flt) && $stable(st_r.ival))
    else $error("value changed in hold mode");

  a_relink_permit: assert property (s_relink |=> st_r.tag_ok[$past(upd_dev)])
    else $error("tag refresh not permitted after relink");

endmodule : igrm_top
`default_nettype wire

/* File: tb/igrm_host.sv */
`timescale 1ns/10ps
`default_nettype none
module igrm_host (
  input  wire logic        clock,
  output logic             rd_req,
  output logic [15:0]      rd_addr,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data
);
  initial begin
    rd_req  = 1'b0;
    rd_addr = 16'h0000;
  end

  // Zero-based register number straight onto the wire
  task read(input logic [15:0] num, output logic [15:0] val, output logic late);
    @(posedge clock);
    rd_req  <= 1'b1;
    rd_addr <= num;
    @(posedge clock);
    rd_req  <= 1'b0;
    rd_addr <= ~num;
    #1;
    late = (rd_valid !== 1'b1);
    val  = rd_data;
  endtask : read
endmodule : igrm_host
`default_nettype wire

/* File: tb/igrm_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module igrm_bench
  import igrm_pkg::*;
;
  logic        clock                   = 1'b0;
  logic        nrst                    = 1'b0;
  logic        monitor_en              = 1'b1;
  logic        cfg_extended            = 1'b0;
  logic        cfg_high_half_first     = 1'b0;
  logic [1:0]  cfg_fail_mode           = 2'h0;
  logic [31:0] cfg_preset_float        = 32'h44f9e000;
  logic [15:0] cfg_preset_int          = 16'h07cf;
  logic [1:0]  cfg_decimal_point_count = 2'h0;
  logic [15:0] gw_status               = 16'h5a3c;
  logic        upd_valid               = 1'b0;
  logic [2:0]  upd_kind                = 3'h0;
  logic [3:0]  upd_dev                 = 4'h0;
  logic [4:0]  upd_sel                 = 5'h00;
  logic [31:0] upd_data                = 32'h00000000;
  logic [15:0] upd_int                 = 16'h0000;
  logic [3:0]  tag_dev                 = 4'h0;
  logic        rd_req;
  logic [15:0] rd_addr;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic [63:0] tag_data;
  logic [15:0] dev_found;
  logic [15:0] dev_failed;
  int          errors                  = 0;
  int          checks_done             = 0;
  int          cycles                  = 0;

  always #2 clock = ~clock;

  igrm_top DUT (
    .clock, .nrst, .monitor_en, .cfg_extended, .cfg_high_half_first, .cfg_fail_mode,
    .cfg_preset_float, .cfg_preset_int, .cfg_decimal_point_count, .gw_status,
    .upd_valid, .upd_kind, .upd_dev, .upd_sel, .upd_data, .upd_int,
    .rd_req, .rd_addr, .rd_valid, .rd_data, .tag_dev, .tag_data, .dev_found, .dev_failed
  );

  igrm_host u_host (.clock, .rd_req, .rd_addr, .rd_valid, .rd_data);

  task summarize;
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task rdchk(input logic [15:0] num, input logic [15:0] exp);
    logic [15:0] v;
    logic        late;
    u_host.read(num, v, late);
    chk({63'h0, late}, 64'h0);
    chk({48'h0, v}, {48'h0, exp});
  endtask : rdchk

  task upd(input igrm_upd_kind_type k, input logic [3:0] d, input logic [4:0] s,
           input logic [31:0] data, input logic [15:0] iv = 16'h0000);
    @(posedge clock);
    upd_valid <= 1'b1;
    upd_kind  <= k;
    upd_dev   <= d;
    upd_sel   <= s;
    upd_data  <= data;
    upd_int   <= iv;
    @(posedge clock);
    upd_valid <= 1'b0;
  endtask : upd

  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    int          p;
    logic [15:0] exp;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    rdchk(16'h007f, 16'h5a3c);
    rdchk(16'h0070, 16'h0000);
    rdchk(16'h007e, 16'h0000);
    rdchk(16'h0080, 16'h0000);
    // One variable per instrument, decimal count stepped 0..3
    for (int v = 0; v < 4; v++) begin
      p = v + 3;
      repeat (v) p = p * 10;
      @(posedge clock) cfg_decimal_point_count <= 2'(v);
      upd(IGRM_UPD_VALUE, 4'(v + 1), 5'(v), {16'h4100 + 16'(v), 16'h0200 + 16'(v)}, 16'(v + 3));
      rdchk(16'(17 * v + 1), 16'(p));
      rdchk(16'(258 + 34 * v), 16'h0200 + 16'(v));
      rdchk(16'(259 + 34 * v), 16'h4100 + 16'(v));
    end
    chk({48'h0, dev_found}, 64'h001e);
    upd(IGRM_UPD_VALUE, 4'h5, 5'h00, 32'h00000000, 16'h0100);
    upd(IGRM_UPD_VALUE, 4'h5, 5'h01, 32'h00000000, 16'hff00);
    rdchk(16'h0005, 16'h7fff);
    rdchk(16'h0015, 16'h8000);
    @(posedge clock) cfg_high_half_first <= 1'b1;
    rdchk(16'h0102, 16'h4100);
    @(posedge clock) cfg_high_half_first <= 1'b0;
    @(posedge clock) monitor_en <= 1'b0;
    upd(IGRM_UPD_VALUE, 4'h1, 5'h00, 32'h11111111, 16'h0063);
    rdchk(16'h0001, 16'h0003);
    upd(IGRM_UPD_STATUS, 4'h9, 5'h00, 32'h0000c0de);
    rdchk(16'h0049, 16'hc0de);
    for (int u = 0; u < 4; u++) begin
      upd(IGRM_UPD_UNIT, 4'h9, 5'(u), 32'(8'h20 + u));
    end
    rdchk(16'h0059, 16'h2021);
    rdchk(16'h0069, 16'h2223);
    // Failure handling in preset and not-a-number modes
    @(posedge clock) cfg_fail_mode <= IGRM_FAIL_PRESET;
    upd(IGRM_UPD_FAIL, 4'h1, 5'h00, 32'h00000000);
    rdchk(16'h0001, 16'h07cf);
    rdchk(16'h0102, 16'he000);
    @(posedge clock) cfg_fail_mode <= IGRM_FAIL_NAN;
    upd(IGRM_UPD_FAIL, 4'h4, 5'h00, 32'h00000000);
    rdchk(16'h0168, 16'h0000);
    rdchk(16'h0169, 16'h7fc0);
    rdchk(16'h0034, 16'h1770);
    chk({48'h0, dev_failed}, 64'h0012);
    // Tag written once, refused, then accepted after relink
    @(posedge clock) tag_dev <= 4'h6;
    upd(IGRM_UPD_TAG, 4'h6, 5'h00, 32'h4c4f4f50);
    upd(IGRM_UPD_TAG, 4'h6, 5'h01, 32'h33412020);
    repeat (2) @(posedge clock);
    #1;
    chk(tag_data, 64'h4c4f4f50_33412020);
    upd(IGRM_UPD_TAG, 4'h6, 5'h00, 32'h58585858);
    upd(IGRM_UPD_TAG, 4'h6, 5'h01, 32'h58585858);
    repeat (2) @(posedge clock);
    #1;
    chk(tag_data, 64'h4c4f4f50_33412020);
    upd(IGRM_UPD_FAIL, 4'h6, 5'h00, 32'h00000000);
    upd(IGRM_UPD_LINK_OK, 4'h6, 5'h00, 32'h00000000);
    upd(IGRM_UPD_TAG, 4'h6, 5'h00, 32'h58585858);
    upd(IGRM_UPD_TAG, 4'h6, 5'h01, 32'h58585858);
    repeat (2) @(posedge clock);
    #1;
    chk(tag_data, 64'h58585858_58585858);
    chk({48'h0, dev_failed}, 64'h0012);
    // Hold mode keeps the last values
    @(posedge clock) cfg_fail_mode <= IGRM_FAIL_HOLD;
    upd(IGRM_UPD_FAIL, 4'h3, 5'h00, 32'h00000000);
    rdchk(16'h0023, 16'h01f4);
    rdchk(16'h0146, 16'h0202);
    chk({48'h0, dev_failed}, 64'h001a);
    // Extra status bytes, only the received count shows
    upd(IGRM_UPD_EXTRA_LEN, 4'h2, 5'h00, 32'h00000003);
    for (int b = 0; b < 5; b++) begin
      upd(IGRM_UPD_EXTRA_BYTE, 4'h2, 5'(b), 32'(8'ha0 + b));
    end
    for (int b = 0; b < 5; b++) begin
      exp = (b < 3) ? 16'(8'ha0 + b) : 16'h0000;
      rdchk(16'(524 + b), exp);
      rdchk(16'(1050 + b), 16'h0000);
    end
    @(posedge clock) cfg_extended <= 1'b1;
    upd(IGRM_UPD_EXTRA_LEN, 4'h2, 5'h00, 32'h00000019);
    upd(IGRM_UPD_EXTRA_BYTE, 4'h2, 5'h18, 32'h0000005e);
    upd(IGRM_UPD_EXTRA_BYTE, 4'h2, 5'h06, 32'h00000066);
    rdchk(16'h0432, 16'h005e);
    rdchk(16'h041c, 16'h00a2);
    rdchk(16'h0420, 16'h0066);
    rdchk(16'h0212, 16'h0000);
    summarize();
  end
endmodule : igrm_bench
`default_nettype wire
